// File: design/fuse_reload_timer.sv
`timescale 1ns/1ps
`default_nettype none

module fuse_reload_timer #(
  parameter int CYCLES = trim_status_pkg::RELOAD_CYCLES
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic restart_in,
  output logic busy_out,
  output logic done_out
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CNT_W-1:0] cnt;
  } timer_s;

  timer_s st;
  timer_s next_st;

  // ---------------------------------------------------------------
  // Reload sequencing
  // ---------------------------------------------------------------
  // Busy from reset until the count runs out; a restart begins afresh
  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    if (restart_in)
    begin
      next_st.busy = 1'b1;
      next_st.cnt = '0;
    end
    else if (st.busy)
    begin
      if (st.cnt == LAST)
      begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
      else
      begin
        next_st.cnt = st.cnt + 1'b1;
      end
    end
  end

  // Registered state, busy is the reset value
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.busy <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign busy_out = st.busy;
  assign done_out = st.done;

  // Busy must end within the programmed count
  chk_busy_bounded: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    (st.busy && st.cnt == LAST && !restart_in) |=> (!st.busy && st.done))
    else $error("reload did not end at its last count");

endmodule

`default_nettype wire

// File: design/trim_status_pkg.sv
package trim_status_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] OFFS_RESONANCE_Y = 8'h0f;
  localparam logic [7:0] OFFS_RESONANCE_Z = 8'h10;
  localparam logic [7:0] OFFS_STATUS_FIRST = 8'h11;

  // Reset values
  localparam logic [7:0] RST_RESONANCE_Y = 8'h00;
  localparam logic [7:0] RST_RESONANCE_Z = 8'h00;
  localparam logic [7:0] RST_STATUS_FIRST = 8'h80;

  // ---------------------------------------------------------------
  // Field positions of status_flags_first
  // ---------------------------------------------------------------
  localparam int BIT_RELOAD_BUSY = 7;
  localparam int BIT_RELOAD_COMPLETE = 6;
  localparam int BIT_WRITE_ERR = 5;
  localparam int BIT_FIFO_READY = 4;
  localparam int BIT_WATERMARK = 3;
  localparam int BIT_OVERRUN = 2;
  localparam int BIT_FIFO_FULL = 1;
  localparam int BIT_PARITY_ERR = 0;

  // Trim step per count, for software scaling
  localparam int STEP_HZ_Y = 15;
  localparam int STEP_HZ_Z = 10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RELOAD_TIME_NS = 2200000;
  // Least time, rounded up to whole cycles
  localparam int RELOAD_CYCLES = (RELOAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // FIFO capacity
  // ---------------------------------------------------------------
  localparam int FIFO_DEPTH = 320;
  localparam int FIFO_DEPTH_THREE_CH = 318;
  localparam int FIFO_PTR_W = 9;

  typedef enum logic [1:0] {
    FIFO_NORMAL,
    FIFO_STREAM,
    FIFO_TRIGGER,
    FIFO_OFF
  } fifo_mode_e;

endpackage

// File: design/trim_status_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Function
// - Y trim: signed byte, 15 Hz steps
// - Z trim: signed byte, 10 Hz steps
// - Reset or soft reset reloads fuses, 2.2 ms
// - Busy bit 7 high until reload ends
// - Busy visible on first interrupt pin
// - Reload end sets sticky complete bit 6
// - Write during busy sets error bit 5
// - Bit 4 high while FIFO holds data
// - Watermark bit 3 on write or overrun ending above level, read-clear
// - SPI: watermark clears after read and deselect
// - Overrun bit 2, pointer to set start
// - First read after overrun is first axis
// - Overrun undefined in normal mode
// - Full bit 1 at 320, or 318
// - Parity sticky bit 0, edge or level source
// - Status read clears parity sticky bit
// - Status at 0x11, resets to 0x80
module trim_status_regs #(
  parameter int RELOAD_CYCLES = trim_status_pkg::RELOAD_CYCLES,
  parameter int DEPTH = trim_status_pkg::FIFO_DEPTH,
  parameter int DEPTH_THREE_CH = trim_status_pkg::FIFO_DEPTH_THREE_CH
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic soft_reset_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic spi_mode_in,
  input wire logic spi_cs_n_in,
  input wire logic [7:0] fuse_trim_y_in,
  input wire logic [7:0] fuse_trim_z_in,
  input wire logic fifo_wr_in,
  input wire logic fifo_rd_in,
  input wire trim_status_pkg::fifo_mode_e fifo_mode_in,
  input wire logic [1:0] chan_count_in,
  input wire logic [8:0] watermark_level_in,
  input wire logic parity_err_in,
  input wire logic edge_vs_level_select_in,
  output logic [7:0] rd_data_out,
  output logic first_irq_pin_out,
  output logic [8:0] fifo_count_out,
  output logic [8:0] fifo_rd_ptr_out,
  output logic [1:0] fifo_rd_axis_out
);

  localparam int PW = trim_status_pkg::FIFO_PTR_W;

  typedef struct packed {
    logic done;
    logic wr_err;
    logic wmark;
    logic wmark_pend;
    logic ovr;
    logic par;
    logic par_prev;
    logic cs_meta;
    logic cs_sync;
    logic [PW-1:0] count;
    logic [PW-1:0] rd_ptr;
    logic [1:0] rd_axis;
    logic [7:0] trim_y;
    logic [7:0] trim_z;
    logic [7:0] rd_data;
    logic irq;
  } regs_s;

  regs_s st;
  regs_s next_st;
  logic busy;
  logic reload_done;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Channels per sample set; zero is treated as one channel
  function automatic logic [1:0] chan_num(input logic [1:0] c);
    chan_num = (c == 2'h0) ? 2'h1 : c;
  endfunction

  // Pointer advance with wrap at the FIFO depth
  function automatic logic [PW-1:0] ptr_add(input logic [PW-1:0] p, input logic [1:0] n);
    logic [PW:0] s;
    s = {1'b0, p} + {{(PW-1){1'b0}}, n};
    if (s >= (PW+1)'(DEPTH))
    begin
      s = s - (PW+1)'(DEPTH);
    end
    ptr_add = s[PW-1:0];
  endfunction

  // Status byte as seen by a read
  function automatic logic [7:0] status_byte(input regs_s s, input logic b, input logic f);
    logic [7:0] v;
    // Busy, ready and full are live levels, so a read never clears them
    v = 8'h00;
    v[trim_status_pkg::BIT_RELOAD_BUSY] = b;
    v[trim_status_pkg::BIT_RELOAD_COMPLETE] = s.done;
    v[trim_status_pkg::BIT_WRITE_ERR] = s.wr_err;
    v[trim_status_pkg::BIT_FIFO_READY] = (s.count != '0);
    v[trim_status_pkg::BIT_WATERMARK] = s.wmark;
    v[trim_status_pkg::BIT_OVERRUN] = s.ovr;
    v[trim_status_pkg::BIT_FIFO_FULL] = f;
    v[trim_status_pkg::BIT_PARITY_ERR] = s.par;
    status_byte = v;
  endfunction

  // ---------------------------------------------------------------
  // Fuse reload timer
  // ---------------------------------------------------------------
  fuse_reload_timer #(
    .CYCLES(RELOAD_CYCLES)
  ) u_reload (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .restart_in(soft_reset_in),
    .busy_out(busy),
    .done_out(reload_done)
  );

  // ---------------------------------------------------------------
  // Combinational next state
  // ---------------------------------------------------------------
  logic stat_rd;
  logic full;
  logic [PW-1:0] cap;
  logic ovr_evt;
  logic wr_take;
  logic rd_take;
  logic par_set;
  logic [1:0] drop;
  logic [PW-1:0] cnt_after;

  // Capacity shrinks with three channels so sets stay whole
  always_comb
  begin
    cap = (chan_num(chan_count_in) == 2'h3) ? PW'(DEPTH_THREE_CH) : PW'(DEPTH);
    full = (st.count >= cap);
    stat_rd = reg_rd_in && (reg_addr_in == trim_status_pkg::OFFS_STATUS_FIRST);
    ovr_evt = fifo_wr_in && full && (fifo_mode_in == trim_status_pkg::FIFO_STREAM
      || fifo_mode_in == trim_status_pkg::FIFO_TRIGGER);
    wr_take = fifo_wr_in && !full;
    rd_take = fifo_rd_in && (st.count != '0) && !ovr_evt;
    drop = chan_num(chan_count_in) - st.rd_axis;
    // Edge source or live level source
    par_set = edge_vs_level_select_in ? (parity_err_in && !st.par_prev) : parity_err_in;
    cnt_after = st.count;
    if (ovr_evt)
    begin
      cnt_after = st.count - PW'(drop) + 1'b1;
    end
    else if (wr_take && !rd_take)
    begin
      cnt_after = st.count + 1'b1;
    end
    else if (rd_take && !wr_take)
    begin
      cnt_after = st.count - 1'b1;
    end
  end

  always_comb
  begin
    next_st = st;
    next_st.par_prev = parity_err_in;
    // Chip select pin passes two flops; only the second is used
    next_st.cs_meta = spi_cs_n_in;
    next_st.cs_sync = st.cs_meta;
    next_st.count = cnt_after;

    // Read pointer walks axis by axis
    if (ovr_evt)
    begin
      next_st.rd_ptr = ptr_add(st.rd_ptr, drop);
      next_st.rd_axis = 2'h0;
    end
    else if (rd_take)
    begin
      next_st.rd_ptr = ptr_add(st.rd_ptr, 2'h1);
      next_st.rd_axis = (st.rd_axis + 2'h1 >= chan_num(chan_count_in)) ? 2'h0
        : st.rd_axis + 2'h1;
    end

    // Trim values land once the fuse contents are valid
    if (reload_done)
    begin
      next_st.trim_y = fuse_trim_y_in;
      next_st.trim_z = fuse_trim_z_in;
    end

    // Read data, registered; clears below do not affect this byte
    if (reg_rd_in)
    begin
      case (reg_addr_in)
        trim_status_pkg::OFFS_RESONANCE_Y: next_st.rd_data = st.trim_y;
        trim_status_pkg::OFFS_RESONANCE_Z: next_st.rd_data = st.trim_z;
        trim_status_pkg::OFFS_STATUS_FIRST: next_st.rd_data = status_byte(st, busy, full);
        default: next_st.rd_data = 8'h00;
      endcase
    end

    // Read-clear of sticky and event bits; busy, ready, full stay live
    if (stat_rd)
    begin
      next_st.done = 1'b0;
      next_st.wr_err = 1'b0;
      next_st.ovr = 1'b0;
      next_st.par = 1'b0;
      if (spi_mode_in)
      begin
        next_st.wmark_pend = st.wmark;
      end
      else
      begin
        next_st.wmark = 1'b0;
      end
    end

    // Over SPI the watermark waits for deselect before clearing
    if (st.wmark_pend && st.cs_sync)
    begin
      next_st.wmark = 1'b0;
      next_st.wmark_pend = 1'b0;
    end

    // Sets win over read-clear in the same cycle
    if (reload_done)
    begin
      next_st.done = 1'b1;
    end
    if (reg_wr_in && busy)
    begin
      next_st.wr_err = 1'b1;
    end
    if (ovr_evt)
    begin
      next_st.ovr = 1'b1;
    end
    if (par_set)
    begin
      next_st.par = 1'b1;
    end
    if ((wr_take || ovr_evt) && (cnt_after > watermark_level_in))
    begin
      next_st.wmark = 1'b1;
      next_st.wmark_pend = 1'b0;
    end

    // Pin shows reload busy, then the watermark event
    next_st.irq = busy || next_st.wmark;
    // Soft reset drops the completion flag of the earlier reload
    if (soft_reset_in)
    begin
      next_st.done = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  // Pin starts high at reset as busy is high; chip select flops start deselected
  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      st <= '0;
      st.irq <= 1'b1;
      st.cs_meta <= 1'b1;
      st.cs_sync <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign rd_data_out = st.rd_data;
  assign first_irq_pin_out = st.irq;
  assign fifo_count_out = st.count;
  assign fifo_rd_ptr_out = st.rd_ptr;
  assign fifo_rd_axis_out = st.rd_axis;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_busy_on_pin: assert property (busy |=> first_irq_pin_out)
    else $error("busy not shown on interrupt pin");

  chk_busy_readback: assert property (
    (stat_rd && busy) |=> rd_data_out[trim_status_pkg::BIT_RELOAD_BUSY])
    else $error("busy bit not read while reloading");

  chk_done_sets: assert property (
    (reload_done && !soft_reset_in) |=> (st.done && !busy))
    else $error("completion flag missing after reload");

  chk_write_error: assert property ((reg_wr_in && busy) |=> st.wr_err)
    else $error("write during reload not flagged");

  chk_ready_live: assert property (
    stat_rd |=> (rd_data_out[trim_status_pkg::BIT_FIFO_READY] == ($past(st.count) != '0)))
    else $error("ready bit does not track FIFO content");

  chk_full_level: assert property (
    stat_rd |=> (rd_data_out[trim_status_pkg::BIT_FIFO_FULL] == $past(full)))
    else $error("full bit wrong at read");

  chk_parity_clear: assert property ((stat_rd && !par_set) |=> !st.par)
    else $error("parity sticky bit survived a read");

  chk_overrun_align: assert property (ovr_evt |=> (st.ovr && st.rd_axis == 2'h0))
    else $error("overrun did not realign read pointer");

  chk_wmark_hold: assert property (
    (st.wmark && st.wmark_pend && !st.cs_sync) |=> st.wmark)
    else $error("watermark cleared before deselect");

  chk_trim_load: assert property (
    reload_done |=> (st.trim_y == $past(fuse_trim_y_in) && st.trim_z == $past(fuse_trim_z_in)))
    else $error("trim bytes not loaded at reload end");

  // A push or overrun that ends above the level raises the event
  chk_wmark_event: assert property (
    ((wr_take || ovr_evt) && (cnt_after > watermark_level_in)) |=> st.wmark)
    else $error("watermark event not raised");

  cov_reload_end: cover property (busy ##1 !busy);
  cov_overrun: cover property (ovr_evt ##[1:20] fifo_rd_in);
  cov_spi_wmark: cover property (st.wmark_pend ##[1:50] !st.wmark);
  cov_write_err: cover property (reg_wr_in && busy);

endmodule

`default_nettype wire

// File: sim/host_port_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_port_model (
  input wire logic ref_clk_in,
  input wire logic [7:0] rd_data_in,
  output logic [7:0] reg_addr_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output logic spi_cs_n_out
);
  // Idle bus, host deselected
  initial
  begin
    reg_addr_out = 8'h00;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    spi_cs_n_out = 1'b1;
  end

  // One-cycle strobe; answer taken the cycle after
  task automatic access(input logic [7:0] addr, input logic wr, output logic [7:0] data);
    @(posedge ref_clk_in) #1;
    reg_addr_out = addr;
    reg_rd_out = !wr;
    reg_wr_out = wr;
    @(posedge ref_clk_in) #1;
    reg_rd_out = 1'b0;
    reg_wr_out = 1'b0;
    reg_addr_out = ~addr; // Released address must not look valid
    data = rd_data_in;
  endtask

  // Chip select framing of a serial transfer
  task automatic select(input logic active);
    @(posedge ref_clk_in) #1;
    spi_cs_n_out = !active;
  endtask
endmodule

`default_nettype wire

// File: sim/trim_and_status_flags_first_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none

module trim_and_status_flags_first_registers_tb;
  // ---------------------------------------------------------------
  // Stimulus and model state
  // ---------------------------------------------------------------
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic soft_reset = 1'b0;
  logic fifo_wr = 1'b0;
  logic fifo_rd = 1'b0;
  logic [7:0] scratch;
  logic spi_mode = 1'b0;
  logic parity = 1'b0;
  logic edge_sel = 1'b0;
  logic [7:0] trim_y;
  logic [7:0] trim_z;
  logic [7:0] rd_data;
  logic [7:0] addr;
  logic rd;
  logic wr;
  logic cs_n;
  logic irq;
  logic [8:0] count;
  logic [8:0] ptr;
  logic [1:0] axis;
  int n_errors = 0;
  int comparisons = 0;
  logic m_busy = 1'b1;
  logic [7:0] m_sticky = 8'h00;
  int m_cnt = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  // Short reload so the run stays brief
  trim_status_regs #(.RELOAD_CYCLES(20)) i_dut (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .soft_reset_in(soft_reset),
    .reg_addr_in(addr),
    .reg_rd_in(rd),
    .reg_wr_in(wr),
    .spi_mode_in(spi_mode),
    .spi_cs_n_in(cs_n),
    .fuse_trim_y_in(trim_y),
    .fuse_trim_z_in(trim_z),
    .fifo_wr_in(fifo_wr),
    .fifo_rd_in(fifo_rd),
    .fifo_mode_in(trim_status_pkg::FIFO_STREAM),
    .chan_count_in(2'h3),
    .watermark_level_in(9'h005),
    .parity_err_in(parity),
    .edge_vs_level_select_in(edge_sel),
    .rd_data_out(rd_data),
    .first_irq_pin_out(irq),
    .fifo_count_out(count),
    .fifo_rd_ptr_out(ptr),
    .fifo_rd_axis_out(axis)
  );

  host_port_model i_host (
    .ref_clk_in(ref_clk_in),
    .rd_data_in(rd_data),
    .reg_addr_out(addr),
    .reg_rd_out(rd),
    .reg_wr_out(wr),
    .spi_cs_n_out(cs_n)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.access(a, 1'b0, d);
    chk("register read", {1'b0, exp}, {1'b0, d});
  endtask

  // Live bits from the model, then drop what a read clears
  task automatic rd_status();
    logic [7:0] e;
    e = m_sticky | {m_busy, 2'h0, m_cnt > 0, 2'h0, m_cnt >= 318, 1'b0};
    rd_reg(8'h11, e);
    m_sticky = m_sticky & (spi_mode ? 8'h08 : 8'h00);
  endtask

  // Back-to-back pushes; a full FIFO drops one whole set of three
  task automatic push(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in) #1;
      fifo_wr = 1'b1;
      m_sticky[2] = m_sticky[2] | (m_cnt == 318);
      m_cnt = (m_cnt == 318) ? m_cnt - 2 : m_cnt + 1;
      m_sticky[3] = m_sticky[3] | (m_cnt > 5);
    end
    @(posedge ref_clk_in) #1;
    fifo_wr = 1'b0;
    cycles(1);
    chk("fifo count", m_cnt[8:0], count);
  endtask

  // Back-to-back pops; caller keeps the FIFO non-empty
  task automatic pop(input int n);
    repeat (n)
    begin
      @(posedge ref_clk_in) #1;
      fifo_rd = 1'b1;
      m_cnt = m_cnt - 1;
    end
    @(posedge ref_clk_in) #1;
    fifo_rd = 1'b0;
    cycles(1);
    chk("fifo count after pop", m_cnt[8:0], count);
  endtask

  task automatic give_verdict();
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    trim_y = lfsr(8'h56);
    trim_z = lfsr(trim_y);
    cycles(5);
    rst_n_in = 1'b1;
    chk("irq after reset", 9'h001, {8'h00, irq});
    rd_status();
    i_host.access(8'h11, 1'b1, scratch);
    m_sticky[5] = 1'b1;
    cycles(25);
    m_busy = 1'b0;
    m_sticky[6] = 1'b1;
    rd_status();
    rd_status();
    rd_reg(8'h0f, trim_y);
    rd_reg(8'h10, trim_z);
    rd_reg(8'h20, 8'h00);
    parity = 1'b1;
    cycles(1);
    parity = 1'b0;
    m_sticky[0] = 1'b1;
    rd_status();
    edge_sel = 1'b1;
    parity = 1'b1;
    cycles(2);
    m_sticky[0] = 1'b1;
    rd_status();
    rd_status();
    parity = 1'b0;
    edge_sel = 1'b0;
    push(1);
    rd_status();
    push(5);
    chk("irq on watermark", 9'h001, {8'h00, irq});
    rd_status();
    push(312);
    rd_status();
    push(1);
    chk("axis after overrun", 9'h000, {7'h00, axis});
    chk("pointer after overrun", 9'h003, ptr);
    rd_status();
    pop(1);
    chk("axis after first pop", 9'h001, {7'h00, axis});
    chk("pointer after first pop", 9'h004, ptr);
    spi_mode = 1'b1;
    i_host.select(1'b1);
    push(1);
    rd_status();
    cycles(8);
    chk("irq while selected", 9'h001, {8'h00, irq});
    i_host.select(1'b0);
    cycles(8);
    m_sticky[3] = 1'b0;
    chk("irq after deselect", 9'h000, {8'h00, irq});
    spi_mode = 1'b0;
    soft_reset = 1'b1;
    cycles(1);
    soft_reset = 1'b0;
    cycles(1);
    m_busy = 1'b1;
    m_sticky[6] = 1'b0;
    chk("irq on soft reset", 9'h001, {8'h00, irq});
    rd_status();
    cycles(25);
    m_busy = 1'b0;
    m_sticky[6] = 1'b1;
    rd_status();
    give_verdict();
  end

  // Run needs about 500 cycles; allow twenty times that
  initial
  begin
    #100000;
    n_errors++;
    give_verdict();
  end
endmodule

`default_nettype wire
